// >>> pkg/lcgsel_map.svh
`ifndef LCGSEL_MAP_SVH
`define LCGSEL_MAP_SVH

// word addresses, not byte addresses, on the register bus
`define LCGSEL_OFF_C1_GATE1 4'h0
`define LCGSEL_OFF_C1_GATE2 4'h1
`define LCGSEL_OFF_C1_GATE3 4'h2
`define LCGSEL_OFF_C1_GATE4 4'h3
`define LCGSEL_OFF_C2_GATE1 4'h4
`define LCGSEL_OFF_C2_GATE2 4'h5
`define LCGSEL_OFF_C2_GATE3 4'h6
`define LCGSEL_OFF_C2_GATE4 4'h7
`define LCGSEL_OFF_MIRROR 4'h8

// pair layout inside one gate select byte: input n uses bits 2n-1 (true) and 2n-2 (inverted)
`define LCGSEL_BIT_IN4_TRUE 7
`define LCGSEL_BIT_IN4_INV 6
`define LCGSEL_BIT_IN3_TRUE 5
`define LCGSEL_BIT_IN3_INV 4
`define LCGSEL_BIT_IN2_TRUE 3
`define LCGSEL_BIT_IN2_INV 2
`define LCGSEL_BIT_IN1_TRUE 1
`define LCGSEL_BIT_IN1_INV 0
`define LCGSEL_BIT_MIRROR_C2 1
`define LCGSEL_BIT_MIRROR_C1 0

`define LCGSEL_RST_SELECT 8'h00
`define LCGSEL_RST_MIRROR 2'h0
`define LCGSEL_READ_LATENCY 1

`endif

// >>> pkg/lcgsel_pkg.sv
package lcgsel_pkg;
    typedef logic [7:0] lcgsel_byte_type;
    typedef logic [3:0] lcgsel_data_type;
    typedef enum logic [1:0] {
        LCGSEL_IDLE = 2'b00,
        LCGSEL_ANSWER = 2'b01
    } lcgsel_bus_state_type;
endpackage

// >>> hw/lcgsel_gate_steer.sv
`timescale 1ns/1ps
// one gate: each data input may feed the gate as true form, inverted form, both or neither
module lcgsel_gate_steer
    import lcgsel_pkg::*;
(
    input wire lcgsel_pkg::lcgsel_byte_type selectBits,
    input wire lcgsel_pkg::lcgsel_data_type dataIn,
    output logic [7:0] gateTerms
);
    import lcgsel_pkg::*;
    `include "lcgsel_map.svh"

    genvar n;
    generate
        for (n = 0; n < 4; n++) begin : g_pair
            // a cleared bit contributes 0 so the gate sees that form as excluded
            assign gateTerms[2*n+1] = selectBits[2*n+1] & dataIn[n];
            assign gateTerms[2*n] = selectBits[2*n] & ~dataIn[n];
        end
    endgenerate
endmodule // lcgsel_gate_steer

// >>> hw/lcgsel_sync2.sv
`timescale 1ns/1ps
// two-flop synchroniser for the cell outputs arriving from the cell logic
module lcgsel_sync2 (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] asyncIn,
    output logic [1:0] syncOut
);
    logic [1:0] stageOne_reg;
    logic [1:0] stageTwo_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stageOne_reg <= 2'h0;
            stageTwo_reg <= 2'h0;
        end else begin
            stageOne_reg <= asyncIn;
            stageTwo_reg <= stageOne_reg;
        end
    end

    assign syncOut = stageTwo_reg;
endmodule // lcgsel_sync2

// >>> hw/lcgsel_top.sv
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module lcgsel_top
    import lcgsel_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire lcgsel_pkg::lcgsel_data_type cell1DataIn,
    input wire lcgsel_pkg::lcgsel_data_type cell2DataIn,
    input wire logic cell1_output,
    input wire logic cell2_output,
    output logic [7:0] cell1Gate1Terms,
    output logic [7:0] cell1Gate2Terms,
    output logic [7:0] cell1Gate3Terms,
    output logic [7:0] cell1Gate4Terms,
    output logic [7:0] cell2Gate1Terms,
    output logic [7:0] cell2Gate2Terms,
    output logic [7:0] cell2Gate3Terms,
    output logic [7:0] cell2Gate4Terms,
    output logic [7:0] cell1Gate4Signal,
    output logic [7:0] cell2Gate4Signal
);
    import lcgsel_pkg::*;
    `include "lcgsel_map.svh"

    // eight select bytes: index = cell*4 + gate
    lcgsel_byte_type select_reg [0:7];
    lcgsel_byte_type select_next [0:7];
    lcgsel_bus_state_type busState_reg;
    lcgsel_bus_state_type busState_next;
    logic [31:0] readData_reg;
    logic [31:0] readData_next;
    logic [1:0] response_reg;
    logic [1:0] response_next;
    logic [1:0] mirrorSync;
    logic [7:0] mirrorByte;
    logic [7:0] c1Terms [0:3];
    logic [7:0] c2Terms [0:3];

    wire hitSelect = (avs_address < `LCGSEL_OFF_MIRROR);
    wire hitMirror = (avs_address == `LCGSEL_OFF_MIRROR);
    wire hitAny = hitSelect | hitMirror;
    wire [2:0] selIndex = avs_address[2:0];
    wire request = avs_read | avs_write;
    wire answering = (busState_reg == LCGSEL_ANSWER);
    // only the low byte lane carries register data
    wire writeLane = avs_byteenable[0];
    // a write lands on the edge that samples waitrequest low, where the master completes it
    wire doWrite = answering & avs_write & hitSelect & writeLane;

    // cell outputs cross from the cell logic, so they pass two flops first
    lcgsel_sync2 u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .asyncIn({cell2_output, cell1_output}),
        .syncOut(mirrorSync)
    );

    // unimplemented upper bits forced low
    assign mirrorByte = {6'h00, mirrorSync[1], mirrorSync[0]};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_gate
            lcgsel_gate_steer u_c1 (
                .selectBits(select_reg[g]),
                .dataIn(cell1DataIn),
                .gateTerms(c1Terms[g])
            );
            lcgsel_gate_steer u_c2 (
                .selectBits(select_reg[g+4]),
                .dataIn(cell2DataIn),
                .gateTerms(c2Terms[g])
            );
        end
    endgenerate

    assign cell1Gate1Terms = c1Terms[0];
    assign cell1Gate2Terms = c1Terms[1];
    assign cell1Gate3Terms = c1Terms[2];
    assign cell1Gate4Terms = c1Terms[3];
    assign cell2Gate1Terms = c2Terms[0];
    assign cell2Gate2Terms = c2Terms[1];
    assign cell2Gate3Terms = c2Terms[2];
    assign cell2Gate4Terms = c2Terms[3];
    // gate 4 product lanes in true/inverted pairs, input 4 at the top
    assign cell1Gate4Signal = {
        c1Terms[3][`LCGSEL_BIT_IN4_TRUE], c1Terms[3][`LCGSEL_BIT_IN4_INV],
        c1Terms[3][`LCGSEL_BIT_IN3_TRUE], c1Terms[3][`LCGSEL_BIT_IN3_INV],
        c1Terms[3][`LCGSEL_BIT_IN2_TRUE], c1Terms[3][`LCGSEL_BIT_IN2_INV],
        c1Terms[3][`LCGSEL_BIT_IN1_TRUE], c1Terms[3][`LCGSEL_BIT_IN1_INV]
    };
    assign cell2Gate4Signal = {
        c2Terms[3][`LCGSEL_BIT_IN4_TRUE], c2Terms[3][`LCGSEL_BIT_IN4_INV],
        c2Terms[3][`LCGSEL_BIT_IN3_TRUE], c2Terms[3][`LCGSEL_BIT_IN3_INV],
        c2Terms[3][`LCGSEL_BIT_IN2_TRUE], c2Terms[3][`LCGSEL_BIT_IN2_INV],
        c2Terms[3][`LCGSEL_BIT_IN1_TRUE], c2Terms[3][`LCGSEL_BIT_IN1_INV]
    };

    // select byte write; writes to the mirror fall through untouched
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            select_next[i] = select_reg[i];
        end
        if (doWrite) begin
            select_next[selIndex] = avs_writedata[7:0];
        end
    end

    // one-cycle answer state: request taken in idle, answered the next cycle
    always_comb begin
        busState_next = busState_reg;
        readData_next = readData_reg;
        response_next = response_reg;
        case (busState_reg)
            LCGSEL_IDLE: begin
                if (request) begin
                    busState_next = LCGSEL_ANSWER;
                    response_next = hitAny ? 2'h0 : 2'h2;
                    if (avs_read && hitSelect) begin
                        readData_next = {24'h000000, select_reg[selIndex]};
                    end else if (avs_read && hitMirror) begin
                        readData_next = {24'h000000, mirrorByte};
                    end else begin
                        readData_next = 32'h00000000;
                    end
                end
            end
            LCGSEL_ANSWER: begin
                busState_next = LCGSEL_IDLE;
            end
            default: begin
                busState_next = LCGSEL_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                select_reg[i] <= `LCGSEL_RST_SELECT;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                select_reg[i] <= select_next[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busState_reg <= LCGSEL_IDLE;
            readData_reg <= 32'h00000000;
            response_reg <= 2'h0;
        end else begin
            busState_reg <= busState_next;
            readData_reg <= readData_next;
            response_reg <= response_next;
        end
    end

    // stall every request in its first cycle so read data comes from a flop
    assign avs_waitrequest = (busState_reg == LCGSEL_IDLE);
    assign avs_readdata = readData_reg;
    assign avs_response = response_reg;
endmodule // lcgsel_top

// >>> bench/lcgsel_sva.sv
`timescale 1ns/1ps
module lcgsel_sva
    import lcgsel_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire lcgsel_pkg::lcgsel_data_type cell1DataIn,
    input wire lcgsel_pkg::lcgsel_data_type cell2DataIn,
    input wire logic cell1_output,
    input wire logic cell2_output,
    input wire logic [7:0] cell1Gate1Terms,
    input wire logic [7:0] cell1Gate4Terms,
    input wire logic [7:0] cell2Gate4Terms,
    input wire logic [7:0] cell1Gate4Signal,
    input wire logic [7:0] cell2Gate4Signal
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [1:0] prevOut_reg;
    logic [2:0] stableCnt_reg;
    wire logic [1:0] curOut = {cell2_output, cell1_output};
    wire logic [7:0] allow = {cell1DataIn[3], ~cell1DataIn[3], cell1DataIn[2], ~cell1DataIn[2],
        cell1DataIn[1], ~cell1DataIn[1], cell1DataIn[0], ~cell1DataIn[0]};
    wire logic [7:0] allowTwo = {cell2DataIn[3], ~cell2DataIn[3], cell2DataIn[2], ~cell2DataIn[2],
        cell2DataIn[1], ~cell2DataIn[1], cell2DataIn[0], ~cell2DataIn[0]};
    wire logic mirrorAns = !avs_waitrequest && avs_read && avs_address == 4'h8;
    // mirror passes a two-flop synchroniser, so only judge it once the cells sat still
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prevOut_reg <= 2'h0;
            stableCnt_reg <= 3'h0;
        end else begin
            prevOut_reg <= curOut;
            stableCnt_reg <= (prevOut_reg != curOut) ? 3'h0
                : (stableCnt_reg == 3'h7 ? 3'h7 : stableCnt_reg + 3'h1);
        end
    end
    a_g4_in4_pair: assert property ((cell1Gate4Terms[7:6] & ~allow[7:6]) == 2'h0)
        else $error("gate 4 input 4 term passes wrong form");
    a_g4_in3_pair: assert property ((cell1Gate4Terms[5:4] & ~allow[5:4]) == 2'h0)
        else $error("gate 4 input 3 term passes wrong form");
    a_g4_in2_pair: assert property ((cell1Gate4Terms[3:2] & ~allow[3:2]) == 2'h0)
        else $error("gate 4 input 2 term passes wrong form");
    a_g4_in1_pair: assert property ((cell1Gate4Terms[1:0] & ~allow[1:0]) == 2'h0)
        else $error("gate 4 input 1 term passes wrong form");
    a_g4_signal_eq: assert property ((cell2Gate4Signal & ~allowTwo) == 8'h00
        && cell2Gate4Signal == cell2Gate4Terms && cell1Gate4Signal == cell1Gate4Terms)
        else $error("gate 4 signal differs from its terms");
    a_g1_same_layout: assert property ((cell1Gate1Terms & ~allow) == 8'h00)
        else $error("gate 1 term passes wrong form");
    a_mirror_upper_zero: assert property (mirrorAns |-> avs_readdata[31:2] == 30'h0)
        else $error("mirror upper bits not zero");
    a_mirror_copy: assert property (mirrorAns && stableCnt_reg >= 3'h5 |-> avs_readdata[1:0] == curOut)
        else $error("mirror bits differ from cell outputs");
endmodule // lcgsel_sva

bind lcgsel_top lcgsel_sva u_sva (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_readdata,
    .avs_waitrequest, .cell1DataIn, .cell2DataIn, .cell1_output, .cell2_output, .cell1Gate1Terms,
    .cell1Gate4Terms, .cell2Gate4Terms, .cell1Gate4Signal, .cell2Gate4Signal);

// >>> bench/lcgsel_tb_top.sv
`timescale 1ns/1ps
module lcgsel_tb_top;
    import lcgsel_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, c1Out = 1'b0, c2Out = 1'b0;
    logic [3:0] avsAddr = 4'h0, avsBe = 4'hF;
    logic [31:0] avsWdata = 32'h0, avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    lcgsel_data_type c1Data = 4'h0, c2Data = 4'h0;
    logic [7:0] t[8], s1, s2;
    int failures = 0, samplesChecked = 0, cycles = 0;
    always #5 sys_clk = ~sys_clk;
    lcgsel_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avsAddr), .avs_read(avsRead),
        .avs_write(avsWrite), .avs_writedata(avsWdata), .avs_byteenable(avsBe),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .cell1DataIn(c1Data), .cell2DataIn(c2Data),
        .cell1_output(c1Out), .cell2_output(c2Out), .cell1Gate1Terms(t[0]),
        .cell1Gate2Terms(t[1]), .cell1Gate3Terms(t[2]), .cell1Gate4Terms(t[3]),
        .cell2Gate1Terms(t[4]), .cell2Gate2Terms(t[5]), .cell2Gate3Terms(t[6]),
        .cell2Gate4Terms(t[7]), .cell1Gate4Signal(s1), .cell2Gate4Signal(s2));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test;
        end
    end
    // one Avalon transfer; held until the edge that samples waitrequest low
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] wd, output logic [31:0] rd);
        @(posedge sys_clk);
        avsAddr <= a;
        avsWdata <= {24'h0, wd};
        if (wr) avsWrite <= 1'b1;
        else avsRead <= 1'b1;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        rd = avs_readdata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    function automatic logic [7:0] steer(input logic [7:0] sel, input logic [3:0] d);
        for (int i = 0; i < 4; i++) begin
            steer[2*i+1] = sel[2*i+1] & d[i];
            steer[2*i] = sel[2*i] & ~d[i];
        end
    endfunction
    task t_reset_and_unmapped;
        logic [31:0] rd;
        for (int a = 0; a < 9; a++) begin
            bus(1'b0, a[3:0], 8'h00, rd);
            check(rd, 32'h0);
        end
        bus(1'b0, 4'hC, 8'h00, rd);
        check({rd[31:2], avs_response}, 32'h2);
    endtask
    task automatic t_steering;
        logic [31:0] rd;
        logic [7:0] sels[3] = '{8'hAA, 8'h55, 8'hC9};
        for (int a = 0; a < 8; a++) begin
            foreach (sels[k]) begin
                bus(1'b1, a[3:0], sels[k], rd);
                bus(1'b0, a[3:0], 8'h00, rd);
                check(rd, {24'h0, sels[k]});
                for (int d = 0; d < 16; d++) begin
                    @(posedge sys_clk);
                    c1Data <= d[3:0];
                    c2Data <= ~d[3:0];
                    @(negedge sys_clk);
                    check(t[a], steer(sels[k], a < 4 ? d[3:0] : ~d[3:0]));
                    if (a == 3) check(s1, steer(sels[k], d[3:0]));
                    if (a == 7) check(s2, steer(sels[k], ~d[3:0]));
                end
            end
        end
        @(posedge sys_clk);
        avsBe <= 4'h0;
        bus(1'b1, 4'h3, 8'h00, rd);
        avsBe <= 4'hF;
        bus(1'b0, 4'h3, 8'h00, rd);
        check(rd, 32'hC9);
    endtask
    task t_mirror;
        logic [31:0] rd;
        for (int v = 0; v < 4; v++) begin
            @(posedge sys_clk);
            {c2Out, c1Out} <= v[1:0];
            repeat (4) @(posedge sys_clk);
            bus(1'b1, 4'h8, 8'hFF, rd);
            check({30'h0, avs_response}, 32'h0);
            bus(1'b0, 4'h8, 8'h00, rd);
            check(rd, {30'h0, v[1:0]});
        end
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset_and_unmapped();
        t_steering();
        t_mirror();
        finish_test();
    end
endmodule // lcgsel_tb_top
